// ==== hdl/ftqc_pkg.sv ====
/*
 * ftqc_pkg: shared constants for the frame transfer queue control block:
 * register offsets, field positions, reset values and transfer states.
 * Assumes a 32-bit APB register bus with word-aligned byte addresses.
 */
package ftqc_pkg;
   // frame buffer size, kilobytes (one region of 256 MB)
   localparam int FTQC_BUF_MB = 256;
   localparam int FTQC_BUF_KB = FTQC_BUF_MB * 1024;

   // register byte offsets
   localparam logic [7:0] FTQC_CTRL_OFS = 8'h00;
   localparam logic [7:0] FTQC_BLOCKS_OFS = 8'h04;
   localparam logic [7:0] FTQC_CMD_OFS = 8'h08;
   localparam logic [7:0] FTQC_STATUS_OFS = 8'h0c;
   localparam logic [7:0] FTQC_OCC_OFS = 8'h10;
   localparam logic [7:0] FTQC_IRQ_STAT_OFS = 8'h14;
   localparam logic [7:0] FTQC_IRQ_CLR_OFS = 8'h18;
   localparam logic [7:0] FTQC_IRQ_EN_OFS = 8'h1c;
   // first of the settings that freeze while acquiring or host linked
   localparam logic [7:0] FTQC_CFG_OFS = 8'h20;
   localparam int FTQC_CFG_NUM = 11;

   // control register fields
   localparam int FTQC_CTRL_COUPLING_BIT = 0;
   localparam int FTQC_CTRL_STYLE_BIT = 1;
   // command register fields
   localparam int FTQC_CMD_BEGIN_BIT = 0;
   localparam int FTQC_CMD_HALT_BIT = 1;
   localparam int FTQC_CMD_KILL_BIT = 2;
   // status register fields
   localparam int FTQC_ST_STREAM_BIT = 0;
   localparam int FTQC_ST_REJECT_BIT = 1;
   localparam int FTQC_ST_LOCK_BIT = 2;
   localparam int FTQC_ST_FULL_BIT = 3;
   // interrupt status / clear / enable fields
   localparam int FTQC_IRQ_W = 3;
   localparam int FTQC_IRQ_DROP_BIT = 0;
   localparam int FTQC_IRQ_DONE_BIT = 1;
   localparam int FTQC_IRQ_REJECT_BIT = 2;

   // reset values
   localparam logic [1:0] FTQC_CTRL_RST = 2'h0;
   localparam logic [31:0] FTQC_BLOCKS_RST = 32'h0000_0001;
   localparam logic [FTQC_IRQ_W-1:0] FTQC_IRQ_EN_RST = 3'h0;
   localparam logic [31:0] FTQC_CFG_RST = 32'h0000_0000;

   // transfer engine states
   typedef enum logic [1:0] {
      FTQC_IDLE = 2'b00,
      FTQC_STREAM = 2'b01,
      FTQC_SENDING = 2'b10
   } ftqc_state_t;
endpackage : ftqc_pkg

// ==== hdl/ftqc_sync.sv ====
/*
 * ftqc_sync: three-stage synchroniser for levels arriving from pins.
 * Assumes nothing of the source; the output changes only once the
 * second and third stages agree, so a lone glitch never passes.
 */
module ftqc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // the first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // accept a new level only when two stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               dout[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule : ftqc_sync

// ==== hdl/ftqc_ring.sv ====
/*
 * ftqc_ring: slot pointers and occupancy of the circular frame buffer.
 * Assumes push marks a frame fully written and pop a block fully sent,
 * each a one-cycle pulse on the same clock.
 */
module ftqc_ring #(
   parameter int DEPTH = 1024,
   parameter int OCC_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic pop,
   input wire logic overwrite_en,
   output logic [$clog2(DEPTH)-1:0] wr_slot,
   output logic [$clog2(DEPTH)-1:0] rd_slot,
   output logic [OCC_W-1:0] occ,
   output logic full,
   output logic lost
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [OCC_W-1:0] DEPTH_C = OCC_W'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic do_pop;
   logic do_push;
   logic do_over;

   assign full = (occ == DEPTH_C);
   assign do_pop = pop && (occ != '0);
   // a pop in the same cycle frees a slot for the incoming frame
   assign do_push = push && (!full || do_pop);
   assign do_over = push && full && !do_pop && overwrite_en;

   // pointers wrap at the slot count, which need not be a power of two
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_slot <= '0;
         rd_slot <= '0;
      end else begin
         if (do_push || do_over) begin
            wr_slot <= (wr_slot == LAST_C) ? '0 : wr_slot + 1'b1;
         end
         if (do_pop || do_over) begin
            rd_slot <= (rd_slot == LAST_C) ? '0 : rd_slot + 1'b1;
         end
      end
   end

   // occupancy: up on a written frame, down on a sent block
   always_ff @(posedge clk) begin
      if (rst) begin
         occ <= '0;
      end else if (do_push && !do_pop) begin
         occ <= occ + 1'b1;
      end else if (do_pop && !do_push) begin
         occ <= occ - 1'b1;
      end
   end

   // a frame arriving on a full buffer with no pop that cycle is lost, overwritten or not
   always_ff @(posedge clk) begin
      if (rst) begin
         lost <= 1'b0;
      end else begin
         lost <= push && full && !do_pop;
      end
   end
endmodule : ftqc_ring

// ==== hdl/ftqc_top.sv ====
/*
 * ftqc_top: frame transfer queue control. Tracks frames held in the
 * circular frame buffer, runs the block transfer engine in coupled or
 * decoupled mode, and exposes settings, commands and status over APB.
 * Assumes the capture path pulses FRAME_DONE per written frame and the
 * link path pulses BLOCK_DONE per fully sent block; ACQ_ACTIVE and
 * HOST_LINKED come from pins and are synchronised here.
 */
import ftqc_pkg::*;

// Behaviour
// (R1) continuous style streams until halt command
// (R2) counted style ends after count or request
// (R3) programmable block count for next transfer
// (R4) readable occupancy of frames awaiting transfer
// (R5) begin, halt and kill transfer commands
// (R6) every frame buffered, then sent promptly
// (R7) frame dropped only when buffer exhausted
// (R8) one 256 MB buffer, resend reserve shrinks it
// (R9) coupled mode paces acquisition by transfer
// (R10) decoupled ring overwrites oldest, flags drop
// (R11) decoupled transfer never stalls capture
// (R12) run style selects continuous or counted
// (R13) count above occupancy is rejected
// (R14) host reads occupancy before counted start
// (R15) listed settings locked while busy
// (R16) occupancy up on write, down on send
// (R17) halt at block end, kill immediate
module ftqc_top #(
   parameter int FRAME_KB = 256,
   parameter int RESEND_KB = 0,
   parameter int OCC_W = 16
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic ACQ_ACTIVE,
   input wire logic HOST_LINKED,
   input wire logic FRAME_DONE,
   output logic ACQ_READY,
   output logic [$clog2((FTQC_BUF_KB - RESEND_KB) / FRAME_KB)-1:0] WR_SLOT,
   output logic BLOCK_START,
   output logic [$clog2((FTQC_BUF_KB - RESEND_KB) / FRAME_KB)-1:0] BLOCK_SLOT,
   input wire logic BLOCK_DONE,
   output logic BLOCK_KILL,
   output logic CFG_LOCKED,
   output logic IRQ
);
   // (R8) slot count from the 256 MB region less the resend reserve
   localparam int SLOTS = (FTQC_BUF_KB - RESEND_KB) / FRAME_KB;
   localparam int AW = $clog2(SLOTS);

   logic [1:0] ctrl_reg;
   logic [31:0] blocks_reg;
   logic [31:0] cfg_reg [FTQC_CFG_NUM];
   logic [FTQC_IRQ_W-1:0] irq_stat_reg;
   logic [FTQC_IRQ_W-1:0] irq_en_reg;
   logic reject_reg;
   logic halt_pend_reg;
   logic [31:0] remain_reg;
   ftqc_state_t state_reg;
   ftqc_state_t state_next;
   logic [1:0] pin_s;
   logic [AW-1:0] rd_slot;
   logic [OCC_W-1:0] occ;
   logic ring_full;
   logic ring_lost;
   logic decoupled;
   logic counted;
   logic setup_ph;
   logic wr_acc;
   logic cfg_hit;
   logic [7:0] cfg_idx;
   logic unmapped;
   logic lock_wr;
   logic cmd_begin;
   logic cmd_halt;
   logic cmd_kill;
   logic begin_ok;
   logic begin_bad;
   logic sent;
   logic count_done;
   logic [FTQC_IRQ_W-1:0] irq_evt;

   assign decoupled = ctrl_reg[FTQC_CTRL_COUPLING_BIT];
   assign counted = ctrl_reg[FTQC_CTRL_STYLE_BIT];

   // pins from outside the clock domain
   ftqc_sync #(
      .W(2)
   ) u_sync (
      .clk(CLK),
      .rst(SYS_RST),
      .din({HOST_LINKED, ACQ_ACTIVE}),
      .dout(pin_s)
   );

   // (R15) lock while acquiring or a host transfer is connected
   assign CFG_LOCKED = pin_s[0] | pin_s[1];

   // (R6) every frame lands in the ring before it is sent
   ftqc_ring #(
      .DEPTH(SLOTS),
      .OCC_W(OCC_W)
   ) u_ring (
      .clk(CLK),
      .rst(SYS_RST),
      .push(FRAME_DONE),
      .pop(sent),
      .overwrite_en(decoupled),
      .wr_slot(WR_SLOT),
      .rd_slot(rd_slot),
      .occ(occ),
      .full(ring_full),
      .lost(ring_lost)
   );

   // (R9) coupled: next grab only once the previous frame has gone
   // (R11) decoupled: capture never waits on the link
   assign ACQ_READY = decoupled ? 1'b1 : (occ == '0);

   // apb decode; zero wait states, so pready is tied high
   assign PREADY = 1'b1;
   assign setup_ph = PSEL && !PENABLE;
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign cfg_idx = (PADDR - FTQC_CFG_OFS) >> 2;
   assign cfg_hit = (PADDR >= FTQC_CFG_OFS) && (cfg_idx < 8'(FTQC_CFG_NUM)) && (PADDR[1:0] == 2'b00);
   assign unmapped = !cfg_hit && !(PADDR inside {FTQC_CTRL_OFS, FTQC_BLOCKS_OFS, FTQC_CMD_OFS,
      FTQC_STATUS_OFS, FTQC_OCC_OFS, FTQC_IRQ_STAT_OFS, FTQC_IRQ_CLR_OFS, FTQC_IRQ_EN_OFS});
   // (R15) refused write to a frozen setting
   assign lock_wr = cfg_hit && CFG_LOCKED;
   assign PSLVERR = PSEL && PENABLE && (unmapped || (PWRITE && lock_wr));

   // (R5) begin, halt, kill strobes from the write-only command register
   assign cmd_begin = wr_acc && PADDR == FTQC_CMD_OFS && PWDATA[FTQC_CMD_BEGIN_BIT];
   assign cmd_halt = wr_acc && PADDR == FTQC_CMD_OFS && PWDATA[FTQC_CMD_HALT_BIT];
   assign cmd_kill = wr_acc && PADDR == FTQC_CMD_OFS && PWDATA[FTQC_CMD_KILL_BIT];

   // (R13) counted request above the buffered frames is refused
   assign begin_bad = cmd_begin && decoupled && counted && (state_reg == FTQC_IDLE)
      && (blocks_reg > 32'(occ));
   assign begin_ok = cmd_begin && (state_reg == FTQC_IDLE) && !begin_bad;

   // (R16) a block counts as sent only when the link reports it
   assign sent = (state_reg == FTQC_SENDING) && BLOCK_DONE && !cmd_kill;
   // (R2) (R12) counted style ends after its last block
   assign count_done = decoupled && counted && (remain_reg == '0);

   // transfer engine next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FTQC_IDLE: begin
            // coupled mode streams on its own as frames arrive
            if (begin_ok || (!decoupled && occ != '0)) begin
               state_next = FTQC_STREAM;
            end
         end
         FTQC_STREAM: begin
            // (R1) continuous runs until halt; (R2) counted until done
            if (cmd_kill || halt_pend_reg || cmd_halt || count_done) begin
               state_next = FTQC_IDLE;
            end else if (occ != '0) begin
               state_next = FTQC_SENDING;
            end
         end
         FTQC_SENDING: begin
            // (R17) kill ends the block now; halt waits for its end
            if (cmd_kill) begin
               state_next = FTQC_IDLE;
            end else if (BLOCK_DONE) begin
               state_next = FTQC_STREAM;
            end
         end
         default: begin
            state_next = FTQC_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg <= FTQC_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // (R17) halt remembered until the block boundary
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         halt_pend_reg <= 1'b0;
      end else if (state_next == FTQC_IDLE) begin
         halt_pend_reg <= 1'b0;
      end else if (cmd_halt) begin
         halt_pend_reg <= 1'b1;
      end
   end

   // (R2) blocks still owed in a counted transfer
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         remain_reg <= '0;
      end else if (begin_ok) begin
         remain_reg <= blocks_reg;
      end else if (sent && remain_reg != '0) begin
         remain_reg <= remain_reg - 1'b1;
      end
   end

   // block request and abort strobes toward the link path
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         BLOCK_START <= 1'b0;
         BLOCK_KILL <= 1'b0;
         BLOCK_SLOT <= '0;
      end else begin
         BLOCK_START <= (state_reg == FTQC_STREAM) && (state_next == FTQC_SENDING);
         // (R17) abort pulse for the block in flight
         BLOCK_KILL <= cmd_kill && (state_reg == FTQC_SENDING);
         if (state_next == FTQC_SENDING && state_reg == FTQC_STREAM) begin
            BLOCK_SLOT <= rd_slot;
         end
      end
   end

   // control and block count registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ctrl_reg <= FTQC_CTRL_RST;
         blocks_reg <= FTQC_BLOCKS_RST;
      end else if (wr_acc) begin
         if (PADDR == FTQC_CTRL_OFS) begin
            ctrl_reg <= PWDATA[1:0];
         end
         // (R3) count for the next counted transfer
         if (PADDR == FTQC_BLOCKS_OFS) begin
            blocks_reg <= PWDATA;
         end
      end
   end

   // (R15) frozen settings; a refused write leaves them untouched
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         for (int i = 0; i < FTQC_CFG_NUM; i++) begin
            cfg_reg[i] <= FTQC_CFG_RST;
         end
      end else if (wr_acc && cfg_hit && !lock_wr) begin
         cfg_reg[cfg_idx[3:0]] <= PWDATA;
      end
   end

   // last begin outcome, kept until the next begin
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         reject_reg <= 1'b0;
      end else if (cmd_begin) begin
         reject_reg <= begin_bad;
      end
   end

   // (R7) (R10) drops come from the ring only when it is full
   assign irq_evt[FTQC_IRQ_DROP_BIT] = ring_lost;
   assign irq_evt[FTQC_IRQ_DONE_BIT] = (state_reg == FTQC_STREAM) && (state_next == FTQC_IDLE);
   assign irq_evt[FTQC_IRQ_REJECT_BIT] = begin_bad;

   // sticky events; a new event wins over a clear in the same cycle
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         irq_stat_reg <= '0;
         irq_en_reg <= FTQC_IRQ_EN_RST;
      end else begin
         if (wr_acc && PADDR == FTQC_IRQ_CLR_OFS) begin
            irq_stat_reg <= (irq_stat_reg & ~PWDATA[FTQC_IRQ_W-1:0]) | irq_evt;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_evt;
         end
         if (wr_acc && PADDR == FTQC_IRQ_EN_OFS) begin
            irq_en_reg <= PWDATA[FTQC_IRQ_W-1:0];
         end
      end
   end

   assign IRQ = |(irq_stat_reg & irq_en_reg);

   // read data captured in the setup phase, shown during access
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         PRDATA <= '0;
      end else if (setup_ph && !PWRITE) begin
         PRDATA <= '0;
         if (cfg_hit) begin
            PRDATA <= cfg_reg[cfg_idx[3:0]];
         end else begin
            unique case (PADDR)
               FTQC_CTRL_OFS: PRDATA <= {30'h0, ctrl_reg};
               FTQC_BLOCKS_OFS: PRDATA <= blocks_reg;
               FTQC_STATUS_OFS: PRDATA <= {28'h0, ring_full, CFG_LOCKED, reject_reg, state_reg != FTQC_IDLE};
               // (R4) frames waiting for the host
               FTQC_OCC_OFS: PRDATA <= 32'(occ);
               FTQC_IRQ_STAT_OFS: PRDATA <= 32'(irq_stat_reg);
               FTQC_IRQ_EN_OFS: PRDATA <= 32'(irq_en_reg);
               default: PRDATA <= '0;
            endcase
         end
      end
   end
endmodule : ftqc_top

// ==== tb/ftqc_top_sva.sv ====
/*
 * ftqc_top_sva: port-level checker for ftqc_top, bound to every instance.
 * Assumes an APB master that never overlaps requests and one link partner.
 */
module ftqc_top_sva import ftqc_pkg::*; #(
   parameter int FRAME_KB = 256,
   parameter int RESEND_KB = 0,
   parameter int OCC_W = 16,
   localparam int AW = $clog2((FTQC_BUF_KB - RESEND_KB) / FRAME_KB)
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic FRAME_DONE,
   input wire logic ACQ_READY,
   input wire logic [AW-1:0] WR_SLOT,
   input wire logic BLOCK_START,
   input wire logic [AW-1:0] BLOCK_SLOT,
   input wire logic BLOCK_DONE,
   input wire logic BLOCK_KILL,
   input wire logic CFG_LOCKED
);
   timeunit 1ns;
   timeprecision 1ns;
   logic acc;
   logic dec_reg;
   logic fly_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   // write access phase; ready is always high so this is the commit edge
   assign acc = PSEL && PENABLE && PWRITE;

   // shadow of the coupling bit, mirrored from host writes
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         dec_reg <= 1'b0;
      end else if (acc && PADDR == FTQC_CTRL_OFS) begin
         dec_reg <= PWDATA[FTQC_CTRL_COUPLING_BIT];
      end
   end

   // one block in flight, from its start pulse to done or kill
   always_ff @(posedge CLK) begin
      if (SYS_RST || BLOCK_DONE || BLOCK_KILL) begin
         fly_reg <= 1'b0;
      end else if (BLOCK_START) begin
         fly_reg <= 1'b1;
      end
   end

   lock_free_a: assert property (acc && !CFG_LOCKED && PADDR >= FTQC_CFG_OFS && PADDR <= 8'h48
      && PADDR[1:0] == 2'b00 |-> !PSLVERR)
      else $error("unlocked setting write refused");
   unmapped_err_a: assert property (PSEL && PENABLE && PADDR > 8'h48 |-> PSLVERR)
      else $error("unmapped access without error");
   lock_refuse_a: assert property (acc && CFG_LOCKED && PADDR >= FTQC_CFG_OFS && PADDR < 8'h4c |-> PSLVERR)
      else $error("locked setting write not refused");
   one_flight_a: assert property (fly_reg |-> !BLOCK_START)
      else $error("second block started while one in flight");
   slot_hold_a: assert property (fly_reg |-> $stable(BLOCK_SLOT))
      else $error("block slot moved during block");
   done_gap_a: assert property (BLOCK_DONE && fly_reg |-> !BLOCK_START ##1 !BLOCK_START)
      else $error("next block too soon after done");
   kill_fast_a: assert property (acc && PADDR == FTQC_CMD_OFS && PWDATA[FTQC_CMD_KILL_BIT] && fly_reg
      |-> ##[1:2] BLOCK_KILL)
      else $error("kill not forwarded to link");
   coupled_pace_a: assert property (!dec_reg && BLOCK_START |-> !ACQ_READY)
      else $error("coupled capture not held while queue busy");
   decoupled_free_a: assert property (dec_reg |-> ACQ_READY)
      else $error("decoupled capture stalled");
   ring_step_a: assert property (FRAME_DONE && dec_reg |=> WR_SLOT == AW'($past(WR_SLOT) + 1'b1))
      else $error("write slot did not advance round the ring");

   kill_seen_c: cover property (BLOCK_KILL);
   done_seen_c: cover property (BLOCK_DONE && fly_reg);
   lock_seen_c: cover property (acc && CFG_LOCKED && PSLVERR);
endmodule : ftqc_top_sva

bind ftqc_top ftqc_top_sva #(.FRAME_KB(FRAME_KB), .RESEND_KB(RESEND_KB), .OCC_W(OCC_W)) u_sva (
   .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_DONE(FRAME_DONE), .ACQ_READY(ACQ_READY),
   .WR_SLOT(WR_SLOT), .BLOCK_START(BLOCK_START), .BLOCK_SLOT(BLOCK_SLOT), .BLOCK_DONE(BLOCK_DONE),
   .BLOCK_KILL(BLOCK_KILL), .CFG_LOCKED(CFG_LOCKED));

// ==== tb/ftqc_link_model.sv ====
/*
 * ftqc_link_model: host end of the link; takes one block per start pulse.
 * Assumes start and kill are one-cycle pulses; lag sets how slow it is.
 */
module ftqc_link_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic block_start,
   input wire logic block_kill,
   input wire logic [7:0] lag,
   output logic block_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_reg;
   logic busy_reg;

   // host drains each block lag+1 cycles after its start pulse, a kill drops it unsent
   always_ff @(posedge clk) begin
      block_done <= 1'b0;
      if (rst || block_kill) begin
         busy_reg <= 1'b0;
      end else if (block_start) begin
         busy_reg <= 1'b1;
         cnt_reg <= lag;
      end else if (busy_reg && cnt_reg == 8'h00) begin
         busy_reg <= 1'b0;
         block_done <= 1'b1;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
endmodule : ftqc_link_model

// ==== tb/frame_transfer_queue_control_tb.sv ====
/*
 * frame_transfer_queue_control_tb: register-level tests of ftqc_top.
 * Assumes four buffer slots (FRAME_KB 65536) and the link model above.
 */
module frame_transfer_queue_control_tb;
   import ftqc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
`define CK(s, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", s, e, g); end end
   logic clk, rst, psel, pen, pwr, acq, lnk, fdone, pready, pslverr, acq_rdy, bstart, bdone, bkill, locked, irq, err;
   logic [7:0] paddr, lag;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] wslot, bslot;
   int n_errors, checks, cyc, kills;

   ftqc_top #(.FRAME_KB(65536)) u_dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ACQ_ACTIVE(acq),
      .HOST_LINKED(lnk), .FRAME_DONE(fdone), .ACQ_READY(acq_rdy), .WR_SLOT(wslot), .BLOCK_START(bstart),
      .BLOCK_SLOT(bslot), .BLOCK_DONE(bdone), .BLOCK_KILL(bkill), .CFG_LOCKED(locked), .IRQ(irq));
   ftqc_link_model u_link (.clk(clk), .rst(rst), .block_start(bstart), .block_kill(bkill), .lag(lag),
      .block_done(bdone));

   // free-running clock, 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // kill pulses and a hang limit well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (bkill === 1'b1) kills++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   // one apb transfer; request held until the edge that samples ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rd_ck(input logic [7:0] a, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      `CK(s, e, rd)
   endtask : rd_ck

   task automatic frames(input int n);
      repeat (n) begin
         fdone <= 1'b1;
         @(posedge clk);
         fdone <= 1'b0;
         @(posedge clk);
      end
   endtask : frames

   // poll a register until the masked value appears, bounded
   task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int i;
      for (i = 0; i < 300; i++) begin
         apb(1'b0, a, 32'h0);
         if ((rd & m) === v) break;
      end
      `CK("poll", v, rd & m)
   endtask : wait_reg

   initial begin
      {psel, pen, pwr, acq, lnk, fdone} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      lag = 8'h04;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_ck(FTQC_CTRL_OFS, 32'h0, "ctrl");
      rd_ck(FTQC_BLOCKS_OFS, FTQC_BLOCKS_RST, "count");
      rd_ck(FTQC_OCC_OFS, 32'h0, "occupancy");
      rd_ck(FTQC_IRQ_EN_OFS, 32'h0, "irq enable");
      rd_ck(8'h80, 32'h0, "unmapped");
      `CK("unmapped err", 1'b1, err)
      $display("test reset done");
      apb(1'b1, FTQC_CTRL_OFS, 32'h3);
      apb(1'b1, FTQC_IRQ_EN_OFS, 32'h7);
      apb(1'b1, FTQC_BLOCKS_OFS, 32'h2);
      apb(1'b1, FTQC_CMD_OFS, 32'h1);
      rd_ck(FTQC_STATUS_OFS, 32'h2, "rejected");
      rd_ck(FTQC_IRQ_STAT_OFS, 32'h4, "reject irq");
      `CK("irq", 1'b1, irq)
      apb(1'b1, FTQC_IRQ_CLR_OFS, 32'h4);
      `CK("irq cleared", 1'b0, irq)
      frames(2);
      rd_ck(FTQC_OCC_OFS, 32'h2, "occupancy");
      apb(1'b1, FTQC_CMD_OFS, 32'h1);
      wait_reg(FTQC_STATUS_OFS, 32'h1, 32'h0);
      rd_ck(FTQC_OCC_OFS, 32'h0, "occupancy");
      rd_ck(FTQC_IRQ_STAT_OFS, 32'h2, "done irq");
      apb(1'b1, FTQC_IRQ_CLR_OFS, 32'h7);
      $display("test counted done");
      lag <= 8'd20;
      apb(1'b1, FTQC_CTRL_OFS, 32'h1);
      frames(3);
      apb(1'b1, FTQC_CMD_OFS, 32'h1);
      apb(1'b1, FTQC_CMD_OFS, 32'h2);
      wait_reg(FTQC_STATUS_OFS, 32'h1, 32'h0);
      rd_ck(FTQC_OCC_OFS, 32'h2, "after halt");
      lag <= 8'd60;
      apb(1'b1, FTQC_CMD_OFS, 32'h1);
      apb(1'b1, FTQC_CMD_OFS, 32'h4);
      wait_reg(FTQC_STATUS_OFS, 32'h1, 32'h0);
      `CK("kills", 1, kills)
      rd_ck(FTQC_OCC_OFS, 32'h2, "after kill");
      lag <= 8'h03;
      apb(1'b1, FTQC_CMD_OFS, 32'h1);
      wait_reg(FTQC_OCC_OFS, 32'hffff, 32'h0);
      rd_ck(FTQC_STATUS_OFS, 32'h1, "still streaming");
      apb(1'b1, FTQC_CMD_OFS, 32'h2);
      wait_reg(FTQC_STATUS_OFS, 32'h1, 32'h0);
      $display("test continuous done");
      apb(1'b1, FTQC_IRQ_CLR_OFS, 32'h7);
      frames(4);
      rd_ck(FTQC_IRQ_STAT_OFS, 32'h0, "no drop yet");
      rd_ck(FTQC_STATUS_OFS, 32'h8, "full");
      frames(1);
      rd_ck(FTQC_IRQ_STAT_OFS, 32'h1, "drop");
      rd_ck(FTQC_OCC_OFS, 32'h4, "ring size");
      `CK("irq drop", 1'b1, irq)
      apb(1'b1, FTQC_IRQ_EN_OFS, 32'h6);
      `CK("irq masked", 1'b0, irq)
      apb(1'b1, FTQC_IRQ_CLR_OFS, 32'h7);
      apb(1'b1, FTQC_CMD_OFS, 32'h1);
      wait_reg(FTQC_OCC_OFS, 32'hffff, 32'h0);
      `CK("last slot", 2'h1, bslot)
      apb(1'b1, FTQC_CMD_OFS, 32'h2);
      wait_reg(FTQC_STATUS_OFS, 32'h1, 32'h0);
      $display("test overflow done");
      acq <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 0; i < FTQC_CFG_NUM; i++) begin
         if (i == 5) acq <= 1'b0;
         if (i == 5) lnk <= 1'b1;
         if (i == 5) repeat (6) @(posedge clk);
         apb(1'b1, FTQC_CFG_OFS + 8'(4 * i), 32'h5a);
         `CK("locked err", 1'b1, err)
         rd_ck(FTQC_CFG_OFS + 8'(4 * i), FTQC_CFG_RST, "locked keep");
      end
      rd_ck(FTQC_STATUS_OFS, 32'h4, "lock bit");
      lnk <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b1, FTQC_CFG_OFS, 32'h5a);
      rd_ck(FTQC_CFG_OFS, 32'h5a, "unlocked");
      $display("test lock done");
      apb(1'b1, FTQC_CTRL_OFS, 32'h0);
      lag <= 8'd40;
      frames(1);
      `CK("coupled hold", 1'b0, acq_rdy)
      wait_reg(FTQC_OCC_OFS, 32'hffff, 32'h0);
      `CK("coupled free", 1'b1, acq_rdy)
      `CK("write slot", 2'h3, wslot)
      $display("test coupled done");
      end_sim();
   end
endmodule : frame_transfer_queue_control_tb
